// *** logic/ppx_crossbar.sv ***
// priority crossbar placing peripheral signals on ports 0-3, plus port cells
// assumes an 8-bit special register port, synchronous pin inputs, one clock
//
// Overview of operation
// - functions take lowest free pin, in priority
// - assigned pins are passed over afterwards
// - skipped pins count as already taken
// - management bus places data and clock together
// - serial port places transmit and receive together
// - first serial port fixed on P0.4/P0.5
// - leftover pins act as plain port pins
// - SPI takes three or four pins
// - port register reads pin level, except on a read for modify
// - analog pin: pull-up, driver, receiver off
// - input mode 1 digital; reset digital
// - drive kind set by mode bit, except on management bus pins
// - management bus pins always open-drain
// - pull-up on open-drain unless disabled
// - pull-up off while pin drives low
// - crossbar off: port 0-3 pins inputs
// - ports 0-3 drivers off; port 4 free
// - first routing register bit layout
// - second register: pull-up off, enable bits
// - read-modify-write reads the latch
`timescale 1ns/1ps
`include "ppx_params.svh"
module ppx_crossbar (
  input  wire logic                 i_ref_clk,              // system clock
  input  wire logic                 i_rst,                  // async reset
  input  wire logic [7:0]           i_sfr_addr,             // register address
  input  wire logic [7:0]           i_sfr_wdata,            // write data
  input  wire logic                 i_sfr_we,               // write strobe
  input  wire logic                 i_sfr_re,               // read strobe
  input  wire logic                 i_sfr_rmw,              // read for modify
  output logic      [7:0]           o_sfr_rdata,            // read data
  input  wire logic [1:0]           i_spi_select_line_mode, // spi select mode
  input  wire logic [`PPX_NFN-1:0]  i_fn_out,               // peripheral data
  input  wire logic [`PPX_NFN-1:0]  i_fn_oe,                // peripheral drives
  output logic      [`PPX_NFN-1:0]  o_fn_in,                // pin level back
  input  wire logic [`PPX_NPIN-1:0] i_pin_in,               // pad levels
  output logic      [`PPX_NPIN-1:0] o_pin_out,              // pad data
  output logic      [`PPX_NPIN-1:0] o_pin_oe,               // pad driver on
  output logic      [`PPX_NPIN-1:0] o_pin_pullup,           // weak pull-up on
  output logic      [`PPX_NPIN-1:0] o_pin_rx_en             // digital receiver
);

  // ==========================================================
  // register file
  localparam logic [7:0] LAT_A [`PPX_NPORT] = '{`PPX_P0_ADDR, `PPX_P1_ADDR,
      `PPX_P2_ADDR, `PPX_P3_ADDR, `PPX_P4_ADDR};

  logic [7:0]             route_first_q;
  logic [7:0]             route_second_q;
  logic [7:0]             route_third_q;
  logic [`PPX_NPIN-1:0]   latch_q;
  logic [`PPX_NPIN-1:0]   mdin_q;
  logic [`PPX_NPIN-1:0]   mdout_q;
  logic [`PPX_NXPIN-1:0]  skip_q;
  logic [7:0]             rdata_d;

  wire xbar_on = route_second_q[`PPX_B_XBAR_ON];
  wire pud_off = route_second_q[`PPX_B_PUD_OFF];

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      route_first_q  <= `PPX_ROUTE_RST;
      route_second_q <= `PPX_ROUTE_RST;
      route_third_q  <= `PPX_ROUTE_RST;
      latch_q <= {`PPX_NPORT{`PPX_LATCH_RST}};
      mdin_q  <= {`PPX_NPORT{`PPX_MDIN_RST}};
      mdout_q <= {`PPX_NPORT{`PPX_MDOUT_RST}};
      skip_q  <= {`PPX_NXPORT{`PPX_SKIP_RST}};
    end else if (i_sfr_we) begin
      if (i_sfr_addr == `PPX_ROUTE1_ADDR) route_first_q <= i_sfr_wdata;
      if (i_sfr_addr == `PPX_ROUTE2_ADDR) route_second_q <= i_sfr_wdata;
      if (i_sfr_addr == `PPX_ROUTE3_ADDR) route_third_q <= i_sfr_wdata & `PPX_ROUTE3_MASK;
      for (int n = 0; n < `PPX_NPORT; n++) begin
        if (i_sfr_addr == LAT_A[n]) latch_q[n*8 +: 8] <= i_sfr_wdata;
        if (i_sfr_addr == `PPX_MDIN0_ADDR + 8'(n)) mdin_q[n*8 +: 8] <= i_sfr_wdata;
        if (i_sfr_addr == `PPX_MDOUT0_ADDR + 8'(n)) mdout_q[n*8 +: 8] <= i_sfr_wdata;
        if (n < `PPX_NXPORT && i_sfr_addr == `PPX_SKIP0_ADDR + 8'(n))
          skip_q[n*8 +: 8] <= i_sfr_wdata;
      end
    end
  end

  // ==========================================================
  // read path
  always_comb begin
    rdata_d = 8'h00;
    if (i_sfr_addr == `PPX_ROUTE1_ADDR) rdata_d = route_first_q;
    if (i_sfr_addr == `PPX_ROUTE2_ADDR) rdata_d = route_second_q;
    if (i_sfr_addr == `PPX_ROUTE3_ADDR) rdata_d = route_third_q;
    for (int n = 0; n < `PPX_NPORT; n++) begin
      if (i_sfr_addr == LAT_A[n])
        rdata_d = i_sfr_rmw ? latch_q[n*8 +: 8] : i_pin_in[n*8 +: 8];
      if (i_sfr_addr == `PPX_MDIN0_ADDR + 8'(n)) rdata_d = mdin_q[n*8 +: 8];
      if (i_sfr_addr == `PPX_MDOUT0_ADDR + 8'(n)) rdata_d = mdout_q[n*8 +: 8];
      if (n < `PPX_NXPORT && i_sfr_addr == `PPX_SKIP0_ADDR + 8'(n))
        rdata_d = skip_q[n*8 +: 8];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_re) begin
      o_sfr_rdata <= rdata_d;
    end
  end

  // ==========================================================
  // priority placement
  wire spi_en  = route_first_q[`PPX_B_SPI];
  wire nss_en  = spi_en && (i_spi_select_line_mode != `PPX_SPI_3WIRE);
  wire smb0_en = route_first_q[`PPX_B_SMB0];
  wire smb1_en = route_third_q[`PPX_B_SMB1];
  wire urt1_en = route_third_q[`PPX_B_URT1];
  wire urt0_en = route_first_q[`PPX_B_URT0];

  // requests indexed by routing code, highest priority at lowest code
  wire [`PPX_NCODE-1:0] req = {urt1_en, urt1_en,
                               smb1_en, smb1_en,
                               route_first_q[`PPX_B_SYSCK],
                               route_first_q[`PPX_B_CP1_ASYNC],
                               route_first_q[`PPX_B_CP1],
                               route_first_q[`PPX_B_CP0_ASYNC],
                               route_first_q[`PPX_B_CP0],
                               smb0_en, smb0_en,
                               nss_en, spi_en, spi_en, spi_en,
                               3'b000};

  ppx_pkg::ppx_code_t ord_c [`PPX_NCODE];
  ppx_pkg::ppx_code_t map_d [`PPX_NXPIN];
  ppx_pkg::ppx_code_t map_q [`PPX_NXPIN];

  always_comb begin
    int n;
    n = 0;
    for (int c = 0; c < `PPX_NCODE; c++) begin
      ord_c[c] = 5'(n);
      if (req[c]) n = n + 1;
    end
  end

  always_comb begin
    int rank;
    rank = 0;
    for (int p = 0; p < `PPX_NXPIN; p++) begin
      map_d[p] = `PPX_C_NONE;
      if (!xbar_on) begin
        map_d[p] = `PPX_C_NONE;
      end else if (urt0_en && p == `PPX_SER_TX_PIN) begin
        map_d[p] = `PPX_C_SER_TX;
      end else if (urt0_en && p == `PPX_SER_RX_PIN) begin
        map_d[p] = `PPX_C_SER_RX;
      end else if (!skip_q[p]) begin
        for (int c = 0; c < `PPX_NCODE; c++) begin
          if (req[c] && ord_c[c] == 5'(rank)) map_d[p] = 5'(c);
        end
        rank = rank + 1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int p = 0; p < `PPX_NXPIN; p++) map_q[p] <= `PPX_C_NONE;
    end else begin
      for (int p = 0; p < `PPX_NXPIN; p++) map_q[p] <= map_d[p];
    end
  end

  // ==========================================================
  // port cells
  logic [`PPX_NPIN-1:0]  oe_d;
  logic [`PPX_NPIN-1:0]  out_d;
  logic [`PPX_NPIN-1:0]  pu_d;
  logic [`PPX_NPIN-1:0]  od_w;
  logic [`PPX_NXPIN-1:0] smb_pin;
  logic [`PPX_NXPIN-1:0] prio_pin;
  logic [`PPX_NXPIN-1:0] spi_pin;

  for (genvar p = 0; p < `PPX_NPIN; p++) begin : g_pin
    ppx_pkg::ppx_code_t code;
    logic data;
    logic want;
    if (p < `PPX_NXPIN) begin : g_x
      assign code = map_q[p];
      assign smb_pin[p] = code == `PPX_C_SDA0 || code == `PPX_C_SCL0 ||
                          code == `PPX_C_SDA1 || code == `PPX_C_SCL1;
      assign prio_pin[p] = code > `PPX_C_SER_RX;
      assign spi_pin[p] = code >= `PPX_C_SCK && code <= `PPX_C_SEL;
    end else begin : g_gp
      assign code = `PPX_C_NONE;
    end
    wire routed = code != `PPX_C_NONE;
    wire en_drv = mdin_q[p] && (p >= `PPX_NXPIN || xbar_on);
    assign data = routed ? i_fn_out[code - 5'h01] : latch_q[p];
    assign want = routed ? i_fn_oe[code - 5'h01] : 1'b1;
    if (p < `PPX_NXPIN) begin : g_od
      assign od_w[p] = !mdout_q[p] || smb_pin[p];
    end else begin : g_pp
      assign od_w[p] = !mdout_q[p];
    end
    assign oe_d[p]  = en_drv && want && (od_w[p] ? !data : 1'b1);
    assign out_d[p] = od_w[p] ? 1'b0 : data;
    assign pu_d[p]  = mdin_q[p] && od_w[p] && !pud_off
                      && !(oe_d[p] && !out_d[p]);
  end

  logic [`PPX_NFN-1:0] fn_in_d;
  always_comb begin
    fn_in_d = '1;
    for (int p = 0; p < `PPX_NXPIN; p++) begin
      for (int k = 0; k < `PPX_NFN; k++) begin
        if (map_q[p] == 5'(k + 1) && mdin_q[p]) fn_in_d[k] = i_pin_in[p];
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_oe     <= '0;
      o_pin_out    <= '0;
      o_pin_pullup <= '0;
      o_pin_rx_en  <= '0;
      o_fn_in      <= '1;
    end else begin
      o_pin_oe     <= oe_d;
      o_pin_out    <= out_d;
      o_pin_pullup <= pu_d;
      o_pin_rx_en  <= mdin_q;
      o_fn_in      <= fn_in_d;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  analog_pin_off_a: assert property (
    1 |=> ((~$past(mdin_q)) & (o_pin_oe | o_pin_pullup | o_pin_rx_en)) == '0)
    else $error("analog pin still has digital cell active");

  xbar_off_quiet_a: assert property (
    !xbar_on |=> o_pin_oe[`PPX_NXPIN-1:0] == '0)
    else $error("port 0-3 driver on while crossbar off");

  uart0_fixed_a: assert property (
    xbar_on && urt0_en |=> map_q[`PPX_SER_TX_PIN] == `PPX_C_SER_TX
                           && map_q[`PPX_SER_RX_PIN] == `PPX_C_SER_RX)
    else $error("first serial port not on fixed pins");

  pullup_low_off_a: assert property (
    (o_pin_pullup & o_pin_oe & ~o_pin_out) == '0)
    else $error("pull-up on while driving low");

  smbus_od_a: assert property (
    1 |=> ($past(smb_pin) & o_pin_out[`PPX_NXPIN-1:0]) == '0)
    else $error("management bus pin driven high");

  skip_unrouted_a: assert property (
    1 |=> ($past(skip_q) & prio_pin) == '0)
    else $error("skipped pin received a function");

  spi_width_a: assert property (
    xbar_on && spi_en && skip_q == '0 |=> $countones(spi_pin) == ($past(nss_en) ? 4 : 3))
    else $error("wrong spi pin count");

  lowest_pin_a: assert property (
    xbar_on && route_first_q == 8'h10 && route_third_q == 8'h00 && skip_q == '0
    |=> map_q[0] == `PPX_C_CP0)
    else $error("first function not on lowest pin");

  pass_over_a: assert property (
    xbar_on && route_first_q == 8'h30 && route_third_q == 8'h00 && skip_q == '0
    |=> map_q[1] == `PPX_C_CP0_ASYNC)
    else $error("second function not on next pin");

  pullup_kind_a: assert property (
    1 |=> ((~$past(od_w)) & o_pin_pullup) == '0 && !($past(pud_off) && o_pin_pullup != '0))
    else $error("pull-up on push-pull pin or while disabled");

  pin_read_a: assert property (
    i_sfr_re && !i_sfr_rmw && i_sfr_addr == `PPX_P0_ADDR
    |=> o_sfr_rdata == $past(i_pin_in[7:0]))
    else $error("port read did not return pin level");

  rmw_latch_a: assert property (
    i_sfr_re && i_sfr_rmw && i_sfr_addr == `PPX_P0_ADDR
    |=> o_sfr_rdata == $past(latch_q[7:0]))
    else $error("modify read did not return latch");

  uart0_cov: cover property (xbar_on && urt0_en ##1 map_q[`PPX_SER_TX_PIN] == `PPX_C_SER_TX);
  spi4_cov: cover property (xbar_on && nss_en ##1 $countones(spi_pin) == 4);
  smb_low_cov: cover property (|(smb_pin & o_pin_oe[`PPX_NXPIN-1:0]));
  skip_cov: cover property (xbar_on && skip_q != '0 && |prio_pin);

endmodule : ppx_crossbar

// *** logic/ppx_params.svh ***
// constants for the priority port crossbar: addresses, reset values,
// bit positions and routing codes; included by the crossbar module
`ifndef PPX_PARAMS_SVH
`define PPX_PARAMS_SVH
`define PPX_NPORT        5
`define PPX_NXPORT       4
`define PPX_NPIN         40
`define PPX_NXPIN        32
`define PPX_NFN          17
`define PPX_NCODE        18
`define PPX_ROUTE1_ADDR  8'hE1
`define PPX_ROUTE2_ADDR  8'hE2
`define PPX_ROUTE3_ADDR  8'hE3
`define PPX_P0_ADDR      8'h80
`define PPX_P1_ADDR      8'h90
`define PPX_P2_ADDR      8'hA0
`define PPX_P3_ADDR      8'hB0
`define PPX_P4_ADDR      8'hC7
`define PPX_MDIN0_ADDR   8'hF1
`define PPX_MDOUT0_ADDR  8'hA4
`define PPX_SKIP0_ADDR   8'hD4
`define PPX_LATCH_RST    8'hFF
`define PPX_MDIN_RST     8'hFF
`define PPX_MDOUT_RST    8'h00
`define PPX_SKIP_RST     8'h00
`define PPX_ROUTE_RST    8'h00
`define PPX_ROUTE3_MASK  8'h03
`define PPX_B_URT0       0
`define PPX_B_SPI        1
`define PPX_B_SMB0       2
`define PPX_B_SYSCK      3
`define PPX_B_CP0        4
`define PPX_B_CP0_ASYNC  5
`define PPX_B_CP1        6
`define PPX_B_CP1_ASYNC  7
`define PPX_B_XBAR_ON    6
`define PPX_B_PUD_OFF    7
`define PPX_B_URT1       0
`define PPX_B_SMB1       1
`define PPX_SPI_3WIRE    2'h0
`define PPX_SER_TX_PIN   4
`define PPX_SER_RX_PIN   5
`define PPX_C_NONE       5'h00
`define PPX_C_SER_TX     5'h01
`define PPX_C_SER_RX     5'h02
`define PPX_C_SCK        5'h03
`define PPX_C_SEL        5'h06
`define PPX_C_SDA0       5'h07
`define PPX_C_SCL0       5'h08
`define PPX_C_CP0        5'h09
`define PPX_C_CP0_ASYNC  5'h0A
`define PPX_C_SDA1       5'h0E
`define PPX_C_SCL1       5'h0F
`endif

// *** logic/ppx_pkg.sv ***
// types shared by the priority port crossbar
// widths are written out here; ppx_params.svh is included but not used
`include "ppx_params.svh"
package ppx_pkg;
  typedef logic [4:0] ppx_code_t;
  typedef logic [7:0] ppx_byte_t;
endpackage : ppx_pkg

// *** dv/ppx_pad_model.sv ***
// pad model: resolves each package pin from crossbar drive and bench drive
// assumes a bench drive wins over the crossbar when enabled
`timescale 1ns/1ps
module ppx_pad_model (
  input  wire logic        i_ref_clk, // clock
  input  wire logic [39:0] i_out,     // crossbar pad data
  input  wire logic [39:0] i_oe,      // crossbar driver on
  input  wire logic [39:0] i_pullup,  // weak pull-up on
  input  wire logic [39:0] i_ext_en,  // bench drives pad
  input  wire logic [39:0] i_ext_val, // bench pad value
  output logic      [39:0] o_pin      // resolved level
);
  logic [39:0] float_q;
  initial float_q = 40'h55_5555_5555;
  // undriven pad without pull-up wanders every cycle
  always @(posedge i_ref_clk) float_q <= ~float_q;
  assign o_pin = (i_ext_en & i_ext_val) | (~i_ext_en & i_oe & i_out)
               | (~i_ext_en & ~i_oe & (i_pullup | float_q));
endmodule : ppx_pad_model

// *** dv/priority_port_crossbar_tb_top.sv ***
// testbench for the priority port crossbar: register tasks and placement tables
// assumes ppx_crossbar and ppx_pad_model are compiled before it
`timescale 1ns/1ps
`include "ppx_params.svh"
module priority_port_crossbar_tb_top;
  // ==========================================
  // wiring
  logic        clk, rst, we, re, rmw;
  logic [7:0]  addr, wdata, rdata, rv;
  logic [1:0]  sel_mode;
  logic [16:0] fn_out, fn_oe, fn_in, exp;
  logic [39:0] pin_in, pin_out, pin_oe, pin_pu, pin_rx, ext_en, ext_val;
  int          mismatches, n_compared, cycles;
  localparam logic [7:0]  xr0_tab [4] = '{8'h13, 8'h06, 8'hFC, 8'h00};
  localparam logic [7:0]  xr2_tab [4] = '{8'h00, 8'h00, 8'h00, 8'h03};
  localparam logic [7:0]  skp_tab [4] = '{8'h21, 8'h02, 8'h00, 8'h00};
  localparam logic [1:0]  mod_tab [4] = '{2'h0, 2'h1, 2'h0, 2'h2};
  // pin per code, code 1 in the low nibble, F = not placed
  localparam logic [67:0] pin_tab [4] = '{68'hF_FFFF_FFF6_FFF3_2154,
    68'hF_FFFF_FFFF_6543_20FF, 68'hF_FFF6_5432_10FF_FFFF, 68'h3_210F_FFFF_FFFF_FFFF};

  ppx_crossbar u_dut (.i_ref_clk(clk), .i_rst(rst), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
    .i_sfr_we(we), .i_sfr_re(re), .i_sfr_rmw(rmw), .o_sfr_rdata(rdata),
    .i_spi_select_line_mode(sel_mode), .i_fn_out(fn_out), .i_fn_oe(fn_oe), .o_fn_in(fn_in),
    .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_pin_pullup(pin_pu),
    .o_pin_rx_en(pin_rx));
  ppx_pad_model u_pads (.i_ref_clk(clk), .i_out(pin_out), .i_oe(pin_oe), .i_pullup(pin_pu),
    .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin(pin_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================
  // tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk);
    we    <= 1'b0;
  endtask : wr
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic m, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rmw  <= m;
    re   <= 1'b1;
    @(posedge clk);
    re   <= 1'b0;
    @(posedge clk);
    #1;
    chk("rdata", 40'(e), 40'(rdata));
  endtask : rchk
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask : settle
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      finish_test();
    end
  end
  // ==========================================
  // sequence
  initial begin
    {we, re, rmw, addr, wdata, sel_mode, fn_out, fn_oe, ext_en, ext_val} = '0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk("rx_en", 40'hFF_FFFF_FFFF, pin_rx);
    chk("oe", 40'h0, pin_oe);
    rchk(`PPX_ROUTE1_ADDR, 1'b0, 8'h00);
    rchk(`PPX_ROUTE2_ADDR, 1'b0, 8'h00);
    rchk(8'h11, 1'b0, 8'h00);
    wr(`PPX_MDOUT0_ADDR + 8'h04, 8'hFF);
    wr(`PPX_P4_ADDR, 8'h5A);
    wr(`PPX_ROUTE1_ADDR, 8'h10);
    settle();
    chk("oe", 40'hFF_0000_0000, pin_oe);
    chk("p4_out", 40'h5A, 40'(pin_out[39:32]));
    // cmp0 alone on pin 0, then cmp0 async next to it
    wr(`PPX_ROUTE2_ADDR, 8'h40);
    settle();
    chk("fn_in", 40'h1_FFFF, 40'(fn_in));
    wr(`PPX_ROUTE1_ADDR, 8'h30);
    settle();
    // placement tables, read back through the pin level of each code
    for (int s = 0; s < 4; s++) begin
      wr(`PPX_ROUTE2_ADDR, 8'h00);
      wr(`PPX_SKIP0_ADDR, skp_tab[s]);
      wr(`PPX_ROUTE1_ADDR, xr0_tab[s]);
      wr(`PPX_ROUTE3_ADDR, xr2_tab[s]);
      sel_mode <= mod_tab[s];
      wr(`PPX_ROUTE2_ADDR, 8'h40);
      ext_en <= 40'hFF;
      for (int p = 0; p < 8; p++) begin
        @(posedge clk);
        ext_val <= ~(40'h1 << p);
        settle();
        for (int c = 0; c < 17; c++) exp[c] = (pin_tab[s][4*c+:4] != 4'(p));
        chk("fn_in", 40'(exp), 40'(fn_in));
      end
    end
    // drive kinds on the last layout: bus pins 0,1, second serial on 2,3
    wr(`PPX_MDOUT0_ADDR, 8'hFF);
    @(posedge clk);
    ext_en <= '0;
    fn_oe  <= '1;
    fn_out <= '0;
    settle();
    chk("oe", 40'hFF, 40'(pin_oe[7:0]));
    chk("out", 40'hF0, 40'(pin_out[7:0]));
    chk("pullup", 40'h00, 40'(pin_pu[7:0]));
    @(posedge clk);
    fn_out <= '1;
    settle();
    chk("oe", 40'hFC, 40'(pin_oe[7:0]));
    chk("pullup", 40'h03, 40'(pin_pu[7:0]));
    wr(`PPX_MDIN0_ADDR, 8'hFB);
    settle();
    chk("rx_en", 40'hFB, 40'(pin_rx[7:0]));
    chk("oe", 40'hF8, 40'(pin_oe[7:0]));
    wr(`PPX_ROUTE2_ADDR, 8'hC0);
    settle();
    chk("pullup", 40'h00, 40'(pin_pu[7:0]));
    wr(`PPX_MDOUT0_ADDR, 8'h00);
    @(posedge clk);
    ext_en  <= 40'hFF;
    ext_val <= 40'hA5;
    rchk(`PPX_P0_ADDR, 1'b0, 8'hA5);
    wr(`PPX_P0_ADDR, 8'h3C);
    rchk(`PPX_P0_ADDR, 1'b1, 8'h3C);
    wr(`PPX_ROUTE2_ADDR, 8'h00);
    settle();
    chk("oe", 40'h0, 40'(pin_oe[31:0]));
    chk("fn_in", 40'h1_FFFF, 40'(fn_in));
    finish_test();
  end
endmodule : priority_port_crossbar_tb_top
